/* shared/eax_pkg.sv */
// engine auxiliary control: constants, reset values and carrier types
package eax_pkg;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int unsigned CLK_HZ = 25_000_000;
	localparam int unsigned SEC_TIME = 1;
	localparam int unsigned SEC_CYCLES = CLK_HZ * SEC_TIME;

	// ----------------------------------------
	// register byte offsets
	// ----------------------------------------
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_TIMERS = 8'h04;
	localparam logic [7:0] OFS_CUT_A = 8'h08;
	localparam logic [7:0] OFS_CUT_B = 8'h0C;
	localparam logic [7:0] OFS_COOLANT = 8'h10;
	localparam logic [7:0] OFS_FANS = 8'h14;
	localparam logic [7:0] OFS_SERVICE = 8'h18;
	localparam logic [7:0] OFS_FUEL = 8'h1C;
	localparam logic [7:0] OFS_STATUS = 8'h20;
	localparam logic [7:0] OFS_COUNTS = 8'h24;

	// ----------------------------------------
	// control register fields
	// ----------------------------------------
	localparam int CTRL_SVC_CLR = 0;
	localparam int CTRL_OIL_CUT = 1;
	localparam int CTRL_CHG_CONN = 2;
	localparam int CTRL_LEVEL_LO = 4;

	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [7:0] RST_IDLE_S = 8'h00;
	localparam logic [7:0] RST_HOLD_S = 8'h0A;
	localparam logic [7:0] RST_GAS_S = 8'h05;
	localparam logic [7:0] RST_CRANK_S = 8'h06;
	localparam logic [15:0] RST_CUT_VOLT = 16'h0064;
	localparam logic [15:0] RST_CUT_RPM = 16'h01F4;
	localparam logic [7:0] RST_CUT_FREQ = 8'h0A;
	localparam logic [7:0] RST_CUT_CHG = 8'h06;
	localparam logic [7:0] RST_OIL_DLY = 8'h02;
	localparam logic [7:0] RST_OVERRUN = 8'h00;
	localparam logic [7:0] RST_COOL_ON = 8'h5A;
	localparam logic [7:0] RST_COOL_OFF = 8'h50;
	localparam logic [7:0] RST_HEAT_ON = 8'h32;
	localparam logic [7:0] RST_HEAT_OFF = 8'h3C;
	localparam logic [7:0] RST_FAN_ON = 8'h5A;
	localparam logic [7:0] RST_FAN_OFF = 8'h50;
	localparam logic [12:0] RST_SVC_HRS = 13'h00FA;
	localparam logic [4:0] RST_SVC_MON = 5'h06;
	localparam logic [1:0] RST_SVC_LVL = 2'h3;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef enum logic [1:0] {
		ENG_STOP = 2'b00,
		ENG_IDLE = 2'b01,
		ENG_HOLD = 2'b10,
		ENG_RUN = 2'b11
	} eax_eng_t;

	typedef enum logic [0:0] {
		CR_OFF = 1'b0,
		CR_ON = 1'b1
	} eax_crank_t;

	typedef struct packed {
		logic [15:0] first_phase_volt;
		logic [7:0] freq_hz;
		logic [15:0] rpm;
		logic [7:0] charge_volt;
		logic oil_switch_open;
		logic oil_over_limit;
		logic [7:0] coolant_c;
		logic [7:0] canopy_c;
		logic [7:0] ambient_c;
		logic [7:0] fuel_drop_pct;
		logic [7:0] fuel_rise_pct;
	} eax_meas_t;

	typedef struct packed {
		logic idle;
		logic low_checks_en;
		logic gas_solenoid;
		logic crank;
		logic crank_end;
		logic cooler;
		logic heater;
		logic canopy_fan;
		logic ambient_fan;
		logic service_led;
		logic svc_shutdown;
		logic svc_loaddump;
		logic svc_warning;
		logic fuel_show;
		logic fuel_theft;
		logic fuelling;
	} eax_out_t;

	typedef struct packed {
		logic [7:0] idle_s, hold_s, gas_s, crank_s;
		logic [15:0] cut_volt, cut_rpm;
		logic [7:0] cut_freq, cut_chg, oil_dly, overrun_s;
		logic [7:0] cool_on, cool_off, heat_on, heat_off;
		logic [7:0] can_on, can_off, amb_on, amb_off;
		logic [12:0] svc_hrs;
		logic [4:0] svc_mon;
		logic [1:0] svc_lvl;
		logic oil_cut_en;
		logic chg_conn;
		logic [15:0] tank_cap;
		logic [7:0] cons_hr;
	} eax_cfg_t;

	typedef struct packed {
		eax_cfg_t cfg;
		eax_out_t out;
		eax_eng_t eng;
		eax_crank_t cr;
		logic [31:0] presc;
		logic [7:0] eng_cnt, cr_cnt, oil_cnt, over_cnt;
		logic over_act, hot;
		logic [15:0] hrs_cnt;
		logic [7:0] mon_cnt;
		logic aw_have, w_have;
		logic [7:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic awready, wready, bvalid, arready, rvalid;
		logic [1:0] bresp, rresp;
		logic [31:0] rdata;
	} eax_state_t;

endpackage : eax_pkg

/* tb/eax_ctrl_asserts.sv */
// port checker for the engine auxiliary control block
`timescale 1ns/1ps
`default_nettype none

module eax_ctrl_asserts
	import eax_pkg::*;
#(
	parameter int unsigned SEC_CYC = SEC_CYCLES
) (
	// clock, reset, enable
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic ce_i,
	// engine inputs
	input wire logic running_i,
	input wire logic fired_i,
	input wire logic crank_start_i,
	input wire logic fuel_eval_i,
	// relay functions
	input wire eax_out_t relays_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!arst_n_i);

	property p_idle_start;
		$rose(running_i) && ce_i |=> relays_o.idle;
	endproperty
	a_idle_start: assert property (p_idle_start)
		else $error("idle not raised on run");
	property p_stop_clear;
		!running_i && ce_i |=> !relays_o.idle && !relays_o.low_checks_en;
	endproperty
	a_stop_clear: assert property (p_stop_clear)
		else $error("idle or checks left on after stop");
	property p_idle_quiet;
		relays_o.idle |-> !relays_o.low_checks_en;
	endproperty
	a_idle_quiet: assert property (p_idle_quiet)
		else $error("low checks enabled during idle");
	property p_gas_crank;
		relays_o.gas_solenoid |-> relays_o.crank;
	endproperty
	a_gas_crank: assert property (p_gas_crank)
		else $error("gas open outside cranking");
	property p_fired_cut;
		relays_o.crank && fired_i && ce_i |=> !relays_o.crank
			&& relays_o.crank_end;
	endproperty
	a_fired_cut: assert property (p_fired_cut)
		else $error("crank kept after firing");
	property p_fell_end;
		$fell(relays_o.crank) |-> relays_o.crank_end ##1 !relays_o.crank_end;
	endproperty
	a_fell_end: assert property (p_fell_end)
		else $error("crank end pulse wrong");
	property p_start;
		crank_start_i && ce_i && !relays_o.crank && !relays_o.crank_end
			|=> relays_o.crank;
	endproperty
	a_start: assert property (p_start)
		else $error("crank attempt not started");
	property p_fuel_cause;
		relays_o.fuel_theft || relays_o.fuelling |-> $past(fuel_eval_i);
	endproperty
	a_fuel_cause: assert property (p_fuel_cause)
		else $error("fuel alert without evaluation");
	property p_svc_act;
		relays_o.svc_shutdown || relays_o.svc_loaddump || relays_o.svc_warning
			|-> relays_o.service_led && $onehot({relays_o.svc_shutdown,
			relays_o.svc_loaddump, relays_o.svc_warning});
	endproperty
	a_svc_act: assert property (p_svc_act)
		else $error("service action without single request");

	c_crank_end: cover property (relays_o.crank_end);
	c_checks_on: cover property ($rose(relays_o.low_checks_en));
	c_service: cover property ($rose(relays_o.service_led));
endmodule : eax_ctrl_asserts

bind eax_ctrl eax_ctrl_asserts #(.SEC_CYC(SEC_CYC)) eax_ctrl_asserts_inst (
	.clk_i(clk_i), .arst_n_i(arst_n_i), .ce_i(ce_i),
	.running_i(running_i), .fired_i(fired_i),
	.crank_start_i(crank_start_i), .fuel_eval_i(fuel_eval_i),
	.relays_o(relays_o));
`default_nettype wire

/* tb/eax_ctrl_tb.sv */
// self-checking testbench for the engine auxiliary control block
`timescale 1ns/1ps
`default_nettype none

module eax_ctrl_tb
	import eax_pkg::*;
;
	localparam int SC = 10;
	localparam int LAG = 3;
	logic clk_i = 1'b0;
	logic arst_n_i = 1'b0;
	logic running_i = 1'b0;
	logic fired_i = 1'b0;
	logic crank_start_i = 1'b0;
	logic [2:0] tk = 3'h0;
	eax_meas_t meas;
	eax_meas_t tgt = '0;
	eax_out_t r;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata, v;
	logic [3:0] wstrb = 4'h0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [33:0] rq[$];
	logic [1:0] bq[$];
	int err_total = 0;
	int tests_run = 0;
	int dur = 0, gas_n = 0, end_n = 0, idle_n = 0, th_n = 0, fl_n = 0;
	int d, g, t, i0;
	logic [31:0] cut_a[6] = '{32'hFFFF00E6, 32'hFFFFFFFF, 32'h05DCFFFF,
		32'hFFFFFFFF, 32'hFFFFFFFF, 32'hFFFFFFFF};
	logic [31:0] cut_b[6] = '{32'h0000FFFF, 32'h0000FF32, 32'h0000FFFF,
		32'h00000DFF, 32'h0000FFFF, 32'h00000DFF};
	logic [7:0] cut_c[6] = '{8'h30, 8'h30, 8'h30, 8'h34, 8'h32, 8'h30};
	logic [7:0] t_cool[8] = '{8'h46, 8'h5B, 8'h5A, 8'h4F, 8'h32, 8'h31,
		8'h3C, 8'h3D};
	logic [7:0] t_fan[8] = '{8'h46, 8'h5B, 8'h50, 8'h4F, 8'h50, 8'h50,
		8'h50, 8'h50};
	logic [3:0] t_exp[8] = '{4'h0, 4'hB, 4'hB, 4'h0, 4'h0, 4'h4, 4'h4, 4'h0};

	always #20 clk_i = ~clk_i;

	eax_ctrl #(.SEC_CYC(SC)) eax_ctrl_inst (.clk_i(clk_i),
		.arst_n_i(arst_n_i), .ce_i(1'b1), .meas_i(meas),
		.running_i(running_i), .fired_i(fired_i),
		.crank_start_i(crank_start_i), .hour_tick_i(tk[0]),
		.month_tick_i(tk[1]), .fuel_eval_i(tk[2]), .relays_o(r),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready));
	eax_plant eax_plant_inst (.clk_i(clk_i), .crank_i(r.crank),
		.run_i(running_i), .lag_i(4'(LAG)), .tgt_i(tgt), .meas_o(meas));

	task automatic chk(string n, logic [31:0] e, logic [31:0] s);
		tests_run++;
		if (s !== e) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask : chk

	task automatic finish_test;
		$display("comparisons %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : finish_test

	// ----------------------------------------
	// result watchers
	// ----------------------------------------
	always @(posedge clk_i) begin
		if (rvalid && rready) begin
			chk("rdata", rq[0][31:0], rdata);
			chk("rresp", 32'(rq[0][33:32]), 32'(rresp));
			void'(rq.pop_front());
		end
		if (bvalid && bready) begin
			chk("bresp", 32'(bq[0]), 32'(bresp));
			void'(bq.pop_front());
		end
	end
	always @(negedge clk_i) begin
		dur += int'(r.crank);
		gas_n += int'(r.gas_solenoid);
		end_n += int'(r.crank_end);
		idle_n += int'(r.idle);
		th_n += int'(r.fuel_theft);
		fl_n += int'(r.fuelling);
	end

	// ----------------------------------------
	// bus and stimulus tasks
	// ----------------------------------------
	task automatic wr(logic [7:0] a, logic [31:0] dt, logic [3:0] s = 4'hF,
		logic [1:0] e = RESP_OKAY);
		bq.push_back(e);
		awaddr <= a;
		wdata <= dt;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk_i);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
	endtask : wr

	task automatic rd(logic [7:0] a, logic [31:0] dt,
		logic [1:0] e = RESP_OKAY);
		rq.push_back({e, dt});
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk_i);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
	endtask : rd

	task automatic cyc(int n);
		repeat (n) @(posedge clk_i);
	endtask : cyc

	task automatic pulse(int k);
		tk <= 3'(1 << k);
		cyc(1);
		tk <= 3'h0;
		cyc(2);
	endtask : pulse

	task automatic crank(output int dd, output int gg);
		int d0, g0, e0;
		d0 = dur;
		g0 = gas_n;
		e0 = end_n;
		crank_start_i <= 1'b1;
		cyc(1);
		crank_start_i <= 1'b0;
		cyc(2);
		while (r.crank) cyc(1);
		cyc(2);
		chk("crank_end", 1, end_n - e0);
		dd = dur - d0;
		gg = gas_n - g0;
	endtask : crank

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		tgt.first_phase_volt = 16'h00E6;
		tgt.freq_hz = 8'h32;
		tgt.rpm = 16'h05DC;
		tgt.charge_volt = 8'h0D;
		tgt.oil_switch_open = 1'b1;
		tgt.coolant_c = 8'h46;
		tgt.canopy_c = 8'h46;
		tgt.ambient_c = 8'h46;
		cyc(20);
		arst_n_i <= 1'b1;
		cyc(1);
		void'($urandom(8));
		rd(OFS_CTRL, {26'h0, RST_SVC_LVL, 4'h0});
		rd(OFS_TIMERS, {RST_CRANK_S, RST_GAS_S, RST_HOLD_S, RST_IDLE_S});
		rd(OFS_CUT_A, {RST_CUT_RPM, RST_CUT_VOLT});
		rd(OFS_CUT_B, {RST_OVERRUN, RST_OIL_DLY, RST_CUT_CHG, RST_CUT_FREQ});
		rd(OFS_COOLANT, {RST_HEAT_OFF, RST_HEAT_ON, RST_COOL_OFF, RST_COOL_ON});
		rd(OFS_FANS, {RST_FAN_OFF, RST_FAN_ON, RST_FAN_OFF, RST_FAN_ON});
		rd(OFS_SERVICE, {11'h0, RST_SVC_MON, 3'h0, RST_SVC_HRS});
		rd(OFS_FUEL, 32'h0);
		rd(8'h28, 32'h0, RESP_SLVERR);
		wr(OFS_STATUS, 32'h0, 4'hF, RESP_SLVERR);
		wr(8'h05, 32'h0, 4'hF, RESP_SLVERR);
		v = $urandom();
		wr(OFS_FANS, v);
		wr(OFS_FANS, 32'h000000A5, 4'h1);
		rd(OFS_FANS, {v[31:8], 8'hA5});
		wr(OFS_FANS, 32'h505A505A);
		$display("test registers done");
		for (int i = 0; i < 6; i++) begin
			wr(OFS_CUT_A, cut_a[i]);
			wr(OFS_CUT_B, cut_b[i]);
			wr(OFS_CTRL, {24'h0, cut_c[i]});
			crank(d, g);
			chk("crank_len", (i < 5) ? LAG + 1 : 1, (i < 5) ? d : d > LAG + 1);
			chk("gas_open", i == 5, g > 0);
		end
		chk("crank_bound", 1, d <= 6 * SC + 1 && d >= 5 * SC - 1);
		fired_i <= 1'b1;
		crank(d, g);
		chk("fired_len", 1, d);
		fired_i <= 1'b0;
		$display("test crank done");
		wr(OFS_TIMERS, 32'h06050102);
		i0 = idle_n;
		running_i <= 1'b1;
		t = 0;
		do begin
			cyc(1);
			t++;
		end while (!r.low_checks_en && t < 100);
		d = idle_n - i0;
		chk("idle_len", 1, d >= SC && d <= 2 * SC + 2);
		chk("holdoff", 1, t - d >= 1 && t - d <= SC + 3);
		running_i <= 1'b0;
		cyc(2);
		chk("run_off", 0, {r.idle, r.low_checks_en});
		$display("test idle done");
		for (int i = 0; i < 8; i++) begin
			tgt.coolant_c <= t_cool[i];
			tgt.canopy_c <= t_fan[i];
			tgt.ambient_c <= t_fan[i];
			cyc(3);
			chk("temp_relays", t_exp[i], {r.cooler, r.heater, r.canopy_fan, r.ambient_fan});
		end
		wr(OFS_CUT_B, 32'h0300FFFF);
		tgt.coolant_c <= 8'h5B;
		cyc(3);
		tgt.coolant_c <= 8'h4F;
		cyc(3);
		chk("overrun_on", 1, r.cooler);
		cyc(4 * SC);
		chk("overrun_off", 0, r.cooler);
		$display("test temperature done");
		wr(OFS_SERVICE, 32'h00000002);
		pulse(0);
		chk("svc_early", 0, r.service_led);
		pulse(0);
		chk("svc_hours", 1, r.service_led);
		for (int l = 0; l < 4; l++) begin
			wr(OFS_CTRL, {26'h0, 2'(l), 4'h0});
			cyc(2);
			chk("svc_action", (l == 0) ? 3'h0 : 3'(8 >> l), {r.svc_shutdown, r.svc_loaddump, r.svc_warning});
		end
		wr(OFS_CTRL, 32'h00000031);
		wr(OFS_SERVICE, 32'h00010000);
		pulse(0);
		pulse(0);
		chk("svc_hrs_off", 0, r.service_led);
		pulse(1);
		chk("svc_months", 1, r.service_led);
		rd(OFS_COUNTS, 32'h10002);
		$display("test service done");
		wr(OFS_FUEL, 32'h000A0000);
		chk("fuel_hidden", 0, r.fuel_show);
		i0 = th_n;
		t = fl_n;
		tgt.fuel_drop_pct <= 8'h0B;
		pulse(2);
		tgt.fuel_drop_pct <= 8'h0A;
		tgt.fuel_rise_pct <= 8'h0B;
		pulse(2);
		wr(OFS_FUEL, 32'h00000064);
		cyc(2);
		chk("fuel_shown", 1, r.fuel_show);
		tgt.fuel_drop_pct <= 8'h32;
		pulse(2);
		chk("theft_count", 1, th_n - i0);
		chk("fill_count", 1, fl_n - t);
		rd(OFS_STATUS, 32'h4C);
		$display("test fuel done");
		finish_test();
	end

	initial begin
		cyc(20000);
		err_total++;
		finish_test();
	end
endmodule : eax_ctrl_tb
`default_nettype wire

/* tb/eax_plant.sv */
// far-side model: engine quantities seen by the measurement front end
`timescale 1ns/1ps
`default_nettype none

module eax_plant
	import eax_pkg::*;
(
	// clock
	input wire logic clk_i,
	// engine state from the crank relay and the running input
	input wire logic crank_i,
	input wire logic run_i,
	// spin-up lag and values once turning
	input wire logic [3:0] lag_i,
	input wire eax_meas_t tgt_i,
	// measurements
	output eax_meas_t meas_o
);
	logic [3:0] spin_q = 4'h0;
	logic up;

	always_ff @(posedge clk_i) begin
		if (!(crank_i || run_i)) begin
			spin_q <= 4'h0;
		end else if (spin_q != 4'hF) begin
			spin_q <= spin_q + 4'h1;
		end
	end

	assign up = (crank_i || run_i) && (spin_q >= lag_i);

	// a still engine shows no output, speed or pressure
	always_comb begin
		meas_o = tgt_i;
		if (!up) begin
			meas_o.first_phase_volt = 16'h0000;
			meas_o.freq_hz = 8'h00;
			meas_o.rpm = 16'h0000;
			meas_o.charge_volt = 8'h00;
			meas_o.oil_switch_open = 1'b0;
		end
	end
endmodule : eax_plant
`default_nettype wire

/* verilog/eax_ctrl.sv */
// engine auxiliary relay control with AXI4-Lite register slave
// Function
// - idle output held for idle time after engine starts running
// - low voltage, frequency and speed checks off while idle is active
// - those checks resume only after the holdoff timer expires
// - gas solenoid opens once the gas delay elapsed during cranking
// - crank ends when first phase voltage reaches crank cut voltage
// - crank ends when genset frequency reaches crank cut frequency
// - crank ends when engine speed reaches crank cut speed
// - crank ends when charge voltage reaches crank cut charge voltage
// - charge connected setting enables the charge voltage crank cut
// - oil pressure crank cut after delay when enabled
// - fuel quantity hidden while tank capacity is zero
// - fuel theft and fuelling alerts use hourly consumption, none at zero
// - cooler on above cooler on temperature, off below cooler off
// - heater on below heater on temperature, off above heater off
// - cooler held for fan overrun time after cooling off
// - canopy fan on above turn-on, off below turn-off
// - ambient fan on above turn-on, off below turn-off
// - service request after programmed engine hours, zero disables
// - service request after programmed months, zero disables
// - crank attempt bounded by crank timer, ends early when fired
//
// The address map and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module eax_ctrl
	import eax_pkg::*;
#(
	parameter int unsigned SEC_CYC = SEC_CYCLES
) (
	// clock, reset, enable
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic ce_i,
	// engine and measurement
	input wire eax_meas_t meas_i,
	input wire logic running_i,
	input wire logic fired_i,
	input wire logic crank_start_i,
	input wire logic hour_tick_i,
	input wire logic month_tick_i,
	input wire logic fuel_eval_i,
	// relay functions and indicators
	output eax_out_t relays_o,
	// axi4-lite write
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic hyst(input logic cur, input logic [7:0] t,
			input logic [7:0] on, input logic [7:0] off);
		logic r;
		r = cur;
		if (t > on) begin
			r = 1'b1;
		end else if (t < off) begin
			r = 1'b0;
		end
		return r;
	endfunction : hyst

	function automatic logic [31:0] cfg_word(input eax_cfg_t c,
			input logic [7:0] a);
		logic [31:0] w;
		w = 32'h0000_0000;
		case (a)
			OFS_CTRL: begin
				w[CTRL_OIL_CUT] = c.oil_cut_en;
				w[CTRL_CHG_CONN] = c.chg_conn;
				w[CTRL_LEVEL_LO +: 2] = c.svc_lvl;
			end
			OFS_TIMERS: w = {c.crank_s, c.gas_s, c.hold_s, c.idle_s};
			OFS_CUT_A: w = {c.cut_rpm, c.cut_volt};
			OFS_CUT_B: w = {c.overrun_s, c.oil_dly, c.cut_chg, c.cut_freq};
			OFS_COOLANT: w = {c.heat_off, c.heat_on, c.cool_off, c.cool_on};
			OFS_FANS: w = {c.amb_off, c.amb_on, c.can_off, c.can_on};
			OFS_SERVICE: w = {11'h000, c.svc_mon, 3'h0, c.svc_hrs};
			OFS_FUEL: w = {8'h00, c.cons_hr, c.tank_cap};
			default: w = 32'h0000_0000;
		endcase
		return w;
	endfunction : cfg_word

	function automatic logic cfg_hit(input logic [7:0] a);
		return a[1:0] == 2'h0 && a <= OFS_FUEL;
	endfunction : cfg_hit

	// ----------------------------------------
	// state
	// ----------------------------------------
	eax_state_t s_q;
	eax_state_t s_d;

	logic tick;
	logic cut;
	logic oil_cond;
	logic [31:0] wr_word;
	logic [31:0] rd_word;
	logic svc_clr;
	logic svc_req;

	always_comb begin
		s_d = s_q;
		tick = s_q.presc >= SEC_CYC - 1;
		wr_word = 32'h0000_0000;
		rd_word = 32'h0000_0000;
		svc_clr = 1'b0;
		cut = 1'b0;
		oil_cond = 1'b0;
		svc_req = 1'b0;

		// ----------------------------------------
		// seconds prescaler
		// ----------------------------------------
		s_d.presc = tick ? 32'h0000_0000 : s_q.presc + 32'h0000_0001;

		// ----------------------------------------
		// axi write
		// ----------------------------------------
		if (s_q.awready && s_axi_awvalid) begin
			s_d.aw_have = 1'b1;
			s_d.awready = 1'b0;
			s_d.awaddr = s_axi_awaddr;
		end
		if (s_q.wready && s_axi_wvalid) begin
			s_d.w_have = 1'b1;
			s_d.wready = 1'b0;
			s_d.wdata = s_axi_wdata;
			s_d.wstrb = s_axi_wstrb;
		end
		if (s_q.aw_have && s_q.w_have && !s_q.bvalid) begin
			s_d.aw_have = 1'b0;
			s_d.w_have = 1'b0;
			s_d.bvalid = 1'b1;
			s_d.bresp = cfg_hit(s_q.awaddr) ? RESP_OKAY : RESP_SLVERR;
			wr_word = cfg_word(s_q.cfg, s_q.awaddr);
			for (int b = 0; b < 4; b++) begin
				if (s_q.wstrb[b]) begin
					wr_word[b*8 +: 8] = s_q.wdata[b*8 +: 8];
				end
			end
			case (s_q.awaddr)
				OFS_CTRL: begin
					svc_clr = s_q.wstrb[0] && s_q.wdata[CTRL_SVC_CLR];
					s_d.cfg.oil_cut_en = wr_word[CTRL_OIL_CUT];
					s_d.cfg.chg_conn = wr_word[CTRL_CHG_CONN];
					s_d.cfg.svc_lvl = wr_word[CTRL_LEVEL_LO +: 2];
				end
				OFS_TIMERS: begin
					{s_d.cfg.crank_s, s_d.cfg.gas_s} = wr_word[31:16];
					{s_d.cfg.hold_s, s_d.cfg.idle_s} = wr_word[15:0];
				end
				OFS_CUT_A: {s_d.cfg.cut_rpm, s_d.cfg.cut_volt} = wr_word;
				OFS_CUT_B: begin
					{s_d.cfg.overrun_s, s_d.cfg.oil_dly} = wr_word[31:16];
					{s_d.cfg.cut_chg, s_d.cfg.cut_freq} = wr_word[15:0];
				end
				OFS_COOLANT: begin
					{s_d.cfg.heat_off, s_d.cfg.heat_on} = wr_word[31:16];
					{s_d.cfg.cool_off, s_d.cfg.cool_on} = wr_word[15:0];
				end
				OFS_FANS: begin
					{s_d.cfg.amb_off, s_d.cfg.amb_on} = wr_word[31:16];
					{s_d.cfg.can_off, s_d.cfg.can_on} = wr_word[15:0];
				end
				OFS_SERVICE: begin
					s_d.cfg.svc_mon = wr_word[20:16];
					s_d.cfg.svc_hrs = wr_word[12:0];
				end
				OFS_FUEL: begin
					s_d.cfg.cons_hr = wr_word[23:16];
					s_d.cfg.tank_cap = wr_word[15:0];
				end
				default: ;
			endcase
		end
		if (s_q.bvalid && s_axi_bready) begin
			s_d.bvalid = 1'b0;
			s_d.awready = 1'b1;
			s_d.wready = 1'b1;
		end

		// ----------------------------------------
		// axi read
		// ----------------------------------------
		if (s_q.arready && s_axi_arvalid) begin
			s_d.arready = 1'b0;
			s_d.rvalid = 1'b1;
			s_d.rresp = RESP_OKAY;
			case (s_axi_araddr)
				OFS_STATUS: rd_word = {16'h0000, s_q.out};
				OFS_COUNTS: rd_word = {5'h00, s_q.cr, s_q.eng,
					s_q.mon_cnt, s_q.hrs_cnt};
				default: begin
					rd_word = cfg_word(s_q.cfg, s_axi_araddr);
					if (!cfg_hit(s_axi_araddr)) begin
						s_d.rresp = RESP_SLVERR;
					end
				end
			endcase
			s_d.rdata = rd_word;
		end
		if (s_q.rvalid && s_axi_rready) begin
			s_d.rvalid = 1'b0;
			s_d.arready = 1'b1;
		end

		// ----------------------------------------
		// idle and protection holdoff
		// ----------------------------------------
		if (tick) begin
			s_d.eng_cnt = s_q.eng_cnt + 8'h01;
		end
		case (s_q.eng)
			ENG_STOP: begin
				s_d.eng_cnt = 8'h00;
				if (running_i) begin
					s_d.eng = ENG_IDLE;
				end
			end
			ENG_IDLE: begin
				if (s_q.eng_cnt >= s_q.cfg.idle_s) begin
					s_d.eng = ENG_HOLD;
					s_d.eng_cnt = 8'h00;
				end
			end
			ENG_HOLD: begin
				if (s_q.eng_cnt >= s_q.cfg.hold_s) begin
					s_d.eng = ENG_RUN;
				end
			end
			ENG_RUN: s_d.eng_cnt = 8'h00;
			default: s_d.eng = ENG_STOP;
		endcase
		if (!running_i) begin
			s_d.eng = ENG_STOP;
		end
		s_d.out.idle = s_d.eng == ENG_IDLE;
		s_d.out.low_checks_en = s_d.eng == ENG_RUN;

		// ----------------------------------------
		// cranking
		// ----------------------------------------
		oil_cond = meas_i.oil_switch_open || meas_i.oil_over_limit;
		if (s_q.cr == CR_ON && s_q.cfg.oil_cut_en && oil_cond) begin
			if (tick && s_q.oil_cnt != 8'hFF) begin
				s_d.oil_cnt = s_q.oil_cnt + 8'h01;
			end
		end else begin
			s_d.oil_cnt = 8'h00;
		end
		s_d.out.crank_end = 1'b0;
		case (s_q.cr)
			CR_OFF: begin
				s_d.cr_cnt = 8'h00;
				if (crank_start_i) begin
					s_d.cr = CR_ON;
				end
			end
			CR_ON: begin
				if (tick) begin
					s_d.cr_cnt = s_q.cr_cnt + 8'h01;
				end
				cut = s_q.cr_cnt >= s_q.cfg.crank_s || fired_i;
				cut = cut || meas_i.first_phase_volt >= s_q.cfg.cut_volt;
				cut = cut || meas_i.freq_hz >= s_q.cfg.cut_freq;
				cut = cut || meas_i.rpm >= s_q.cfg.cut_rpm;
				cut = cut || (s_q.cfg.chg_conn &&
					meas_i.charge_volt >= s_q.cfg.cut_chg);
				cut = cut || (s_q.cfg.oil_cut_en && oil_cond &&
					s_q.oil_cnt >= s_q.cfg.oil_dly);
				if (cut) begin
					s_d.cr = CR_OFF;
					s_d.out.crank_end = 1'b1;
				end
			end
			default: s_d.cr = CR_OFF;
		endcase
		s_d.out.crank = s_d.cr == CR_ON;
		s_d.out.gas_solenoid = s_d.cr == CR_ON &&
			s_d.cr_cnt >= s_q.cfg.gas_s;

		// ----------------------------------------
		// coolant, heater and fans
		// ----------------------------------------
		s_d.hot = hyst(s_q.hot, meas_i.coolant_c,
			s_q.cfg.cool_on, s_q.cfg.cool_off);
		if (s_q.hot && !s_d.hot && s_q.cfg.overrun_s != 8'h00) begin
			s_d.over_act = 1'b1;
			s_d.over_cnt = 8'h00;
		end else if (s_d.hot) begin
			s_d.over_act = 1'b0;
		end else if (s_q.over_act) begin
			if (tick) begin
				s_d.over_cnt = s_q.over_cnt + 8'h01;
			end
			if (s_d.over_cnt >= s_q.cfg.overrun_s) begin
				s_d.over_act = 1'b0;
			end
		end
		s_d.out.cooler = s_d.hot || s_d.over_act;
		if (meas_i.coolant_c < s_q.cfg.heat_on) begin
			s_d.out.heater = 1'b1;
		end else if (meas_i.coolant_c > s_q.cfg.heat_off) begin
			s_d.out.heater = 1'b0;
		end
		s_d.out.canopy_fan = hyst(s_q.out.canopy_fan, meas_i.canopy_c,
			s_q.cfg.can_on, s_q.cfg.can_off);
		s_d.out.ambient_fan = hyst(s_q.out.ambient_fan, meas_i.ambient_c,
			s_q.cfg.amb_on, s_q.cfg.amb_off);

		// ----------------------------------------
		// service reminders, a tick beats a clear
		// ----------------------------------------
		if (svc_clr) begin
			s_d.hrs_cnt = 16'h0000;
			s_d.mon_cnt = 8'h00;
		end
		if (hour_tick_i && s_d.hrs_cnt != 16'hFFFF) begin
			s_d.hrs_cnt = s_d.hrs_cnt + 16'h0001;
		end
		if (month_tick_i && s_d.mon_cnt != 8'hFF) begin
			s_d.mon_cnt = s_d.mon_cnt + 8'h01;
		end
		svc_req = (s_d.cfg.svc_hrs != 13'h0000 &&
			s_d.hrs_cnt >= {3'h0, s_d.cfg.svc_hrs});
		svc_req = svc_req || (s_d.cfg.svc_mon != 5'h00 &&
			s_d.mon_cnt >= {3'h0, s_d.cfg.svc_mon});
		s_d.out.service_led = svc_req;
		s_d.out.svc_shutdown = svc_req && s_d.cfg.svc_lvl == 2'h1;
		s_d.out.svc_loaddump = svc_req && s_d.cfg.svc_lvl == 2'h2;
		s_d.out.svc_warning = svc_req && s_d.cfg.svc_lvl == 2'h3;

		// ----------------------------------------
		// fuel
		// ----------------------------------------
		s_d.out.fuel_show = s_d.cfg.tank_cap != 16'h0000;
		s_d.out.fuel_theft = fuel_eval_i && s_q.cfg.cons_hr != 8'h00 &&
			meas_i.fuel_drop_pct > s_q.cfg.cons_hr;
		s_d.out.fuelling = fuel_eval_i && s_q.cfg.cons_hr != 8'h00 &&
			meas_i.fuel_rise_pct > s_q.cfg.cons_hr;
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			s_q <= '0;
			s_q.cfg.idle_s <= RST_IDLE_S;
			s_q.cfg.hold_s <= RST_HOLD_S;
			s_q.cfg.gas_s <= RST_GAS_S;
			s_q.cfg.crank_s <= RST_CRANK_S;
			s_q.cfg.cut_volt <= RST_CUT_VOLT;
			s_q.cfg.cut_rpm <= RST_CUT_RPM;
			s_q.cfg.cut_freq <= RST_CUT_FREQ;
			s_q.cfg.cut_chg <= RST_CUT_CHG;
			s_q.cfg.oil_dly <= RST_OIL_DLY;
			s_q.cfg.overrun_s <= RST_OVERRUN;
			s_q.cfg.cool_on <= RST_COOL_ON;
			s_q.cfg.cool_off <= RST_COOL_OFF;
			s_q.cfg.heat_on <= RST_HEAT_ON;
			s_q.cfg.heat_off <= RST_HEAT_OFF;
			s_q.cfg.can_on <= RST_FAN_ON;
			s_q.cfg.can_off <= RST_FAN_OFF;
			s_q.cfg.amb_on <= RST_FAN_ON;
			s_q.cfg.amb_off <= RST_FAN_OFF;
			s_q.cfg.svc_hrs <= RST_SVC_HRS;
			s_q.cfg.svc_mon <= RST_SVC_MON;
			s_q.cfg.svc_lvl <= RST_SVC_LVL;
			s_q.awready <= 1'b1;
			s_q.wready <= 1'b1;
			s_q.arready <= 1'b1;
		end else if (ce_i) begin
			s_q <= s_d;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign relays_o = s_q.out;
	assign s_axi_awready = s_q.awready;
	assign s_axi_wready = s_q.wready;
	assign s_axi_bvalid = s_q.bvalid;
	assign s_axi_bresp = s_q.bresp;
	assign s_axi_arready = s_q.arready;
	assign s_axi_rvalid = s_q.rvalid;
	assign s_axi_rdata = s_q.rdata;
	assign s_axi_rresp = s_q.rresp;

endmodule : eax_ctrl

`default_nettype wire
